// *** hw/cpu_core_control_front_end.sv ***
`timescale 1ns/100ps
`include "cpu_front_consts.svh"
module cpu_core_control_front_end
	import cpu_front_pkg::*;
#(
	parameter logic [`ADDR_W-1:0] NMI_VECTOR = `DEF_NMI_VECTOR,
	parameter logic [`ADDR_W-1:0] INT_VECTOR = `DEF_INT_VECTOR
)
(
	// clock and resets
	input wire logic core_clk,
	input wire logic rst,
	input wire logic resetPinN,
	output logic coreRst,
	// interrupt pins
	input wire logic nmiN,
	input wire logic intN,
	output logic nmiPending,
	// external bus
	output logic [`ADDR_W-1:0] addrOut,
	output logic addrOutEn,
	input wire logic [`DATA_W-1:0] dataIn,
	output logic [`DATA_W-1:0] dataOut,
	output logic dataOutEn,
	output logic memReqN,
	output logic ioReqN,
	output logic rdN,
	output logic wrN,
	output logic m1N,
	output logic rfshN,
	output space_t space,
	input wire logic waitN,
	input wire logic busReqN,
	output logic busAckN,
	// command port
	input wire logic cmdValid,
	input wire cmd_t cmdCode,
	input wire logic [2:0] cmdReg,
	input wire alu_op_t cmdAlu,
	input wire logic [`ADDR_W-1:0] cmdAddr,
	input wire logic [`DATA_W-1:0] cmdData,
	output logic cmdReady,
	output logic respValid,
	output logic [`DATA_W-1:0] respData,
	// visible state
	output logic [`ADDR_W-1:0] programCounter,
	output logic [`ADDR_W-1:0] stackPointer,
	output logic [`DATA_W-1:0] accum,
	output logic [`DATA_W-1:0] flags,
	output logic [`DATA_W-1:0] instrCode,
	output int_mode_t intMode
);
	state_t state, nextState;
	cmd_t curCmd;
	logic [2:0] curReg;
	logic [1:0] lowCount;
	logic sysRst, nmiPrev, nmiFall, intEnabled, take, intTake;
	logic cycleOn, ackCycle, curIsMem, curIsIo;
	logic fallReq, fallRd, fallWr, fallRfsh;
	addr_op_t aop;
	logic [`ADDR_W-1:0] aAddr, returnAddr, ix, iy, pairVal, pairNew;
	logic [16:0] sum16;
	logic [7:0] intPage, refreshCount, accAlt, flagsAlt;
	logic [7:0] gp [0:`GP_COUNT-1];
	logic [7:0] gpAlt [0:`GP_COUNT-1];
	logic wrEn, aluCarry, aluSub;
	logic [2:0] wrSel;
	logic [7:0] wrVal, operand, aluRes, aluFlags;

	function automatic logic isWrite(input cmd_t c);
		return c == CMD_MEM_WR || c == CMD_IO_WR || c == CMD_PUSH;
	endfunction

	function automatic logic isRead(input cmd_t c);
		return c == CMD_MEM_RD || c == CMD_IO_RD || c == CMD_POP;
	endfunction

	function automatic logic isBus(input cmd_t c);
		return isRead(c) || isWrite(c) || c == CMD_FETCH;
	endfunction

	// reset filter runs on the raw reset only, so it can time the pin
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			lowCount <= 2'h0;
			coreRst <= 1'b1;
		end
		else if (resetPinN)
		begin
			lowCount <= 2'h0;
			coreRst <= 1'b0;
		end
		else if (lowCount == `RST_LOW_CYCLES - 2'h1)
			coreRst <= 1'b1;
		else
			lowCount <= lowCount + 2'h1;
	end

	assign sysRst = rst | coreRst;

	// nmi edge detect; a new edge wins over the service clear
	assign nmiFall = nmiPrev & ~nmiN;
	always_ff @(posedge core_clk)
	begin
		if (sysRst)
		begin
			nmiPrev <= 1'b1;
			nmiPending <= 1'b0;
		end
		else
		begin
			nmiPrev <= nmiN;
			if (nmiFall)
				nmiPending <= 1'b1;
			else if (state == S_IDLE && nextState == S_NMI)
				nmiPending <= 1'b0;
		end
	end

	// acceptance: bus request first, then nmi, then maskable, then command
	assign intTake = state == S_IDLE && busReqN && !nmiPending &&
		!intN && intEnabled;
	assign cmdReady = state == S_IDLE && busReqN && !nmiPending &&
		!intTake;
	assign take = cmdValid & cmdReady;

	// cycle controller next state
	always_comb
	begin
		nextState = state;
		case (state)
			S_IDLE:
				if (!busReqN)
					nextState = S_HOLD;
				else if (nmiPending)
					nextState = S_NMI;
				else if (intTake)
					nextState = S_INTA;
				else if (take && isBus(cmdCode))
					nextState = S_T1;
			S_T1: nextState = S_T2;
			S_INTA: nextState = S_T2;
			S_T2:
				if (waitN)
					nextState = S_T3;
			S_T3: nextState = curCmd == CMD_FETCH ? S_RFSH : S_IDLE;
			S_HOLD:
				if (busReqN)
					nextState = S_IDLE;
			default: nextState = S_IDLE;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (sysRst)
			state <= S_IDLE;
		else
			state <= nextState;
	end

	// latched command, space and write data for the bus cycle
	always_ff @(posedge core_clk)
	begin
		if (sysRst)
		begin
			curCmd <= CMD_FETCH;
			curReg <= `SEL_NONE;
			space <= SP_PROG;
			dataOut <= `RESET_BYTE;
		end
		else if (intTake)
			curCmd <= CMD_INTA;
		else if (take)
		begin
			curCmd <= cmdCode;
			curReg <= cmdReg;
			dataOut <= cmdData;
			if (cmdCode == CMD_FETCH)
				space <= SP_PROG;
			else if (cmdCode == CMD_IO_RD || cmdCode == CMD_IO_WR)
				space <= SP_IO;
			else
				space <= SP_DATA;
		end
	end

	// interrupt mode and enable; acceptance masks further requests
	always_ff @(posedge core_clk)
	begin
		if (sysRst)
		begin
			intMode <= IM_0;
			intEnabled <= 1'b0;
		end
		else if (intTake)
			intEnabled <= 1'b0;
		else if (take && cmdCode == CMD_SET_IM)
		begin
			intMode <= int_mode_t'(cmdData[1:0]);
			intEnabled <= cmdData[2];
		end
	end

	// address unit requests
	always_comb
	begin
		aop = AOP_NONE;
		aAddr = cmdAddr;
		case (state)
			S_IDLE:
				if (take)
					case (cmdCode)
						CMD_FETCH: aop = AOP_FETCH;
						CMD_MEM_RD, CMD_MEM_WR, CMD_IO_RD, CMD_IO_WR:
							aop = AOP_DATA;
						CMD_PUSH: aop = AOP_PUSH;
						CMD_POP: aop = AOP_POP;
						CMD_JUMP: aop = AOP_JUMP;
						CMD_RET: aop = AOP_RET;
						CMD_LD_I: aop = AOP_LDI;
						CMD_LD_SP: aop = AOP_LDSP;
						default: aop = AOP_NONE;
					endcase
			S_T3:
				if (curCmd == CMD_FETCH)
					aop = AOP_RFSH;
				else if (curCmd == CMD_INTA && intMode != IM_0)
				begin
					aop = AOP_VECTOR;
					aAddr = intMode == IM_1 ? INT_VECTOR : {intPage, dataIn};
				end
			S_NMI:
			begin
				aop = AOP_VECTOR;
				aAddr = NMI_VECTOR;
			end
			default: aop = AOP_NONE;
		endcase
	end

	addr_unit u_addr (
		.core_clk(core_clk),
		.sysRst(sysRst),
		.op(aop),
		.opAddr(aAddr),
		.busAddr(addrOut),
		.programCounter(programCounter),
		.stackPointer(stackPointer),
		.returnAddr(returnAddr),
		.intPage(intPage),
		.refreshCount(refreshCount)
	);

	// falling-edge half of bus control; the only negedge logic in the core
	always_ff @(negedge core_clk)
	begin
		if (sysRst)
		begin
			fallReq <= 1'b0;
			fallRd <= 1'b0;
			fallWr <= 1'b0;
			fallRfsh <= 1'b0;
		end
		else
		begin
			fallReq <= cycleOn;
			fallRd <= cycleOn && !isWrite(curCmd);
			fallWr <= state == S_T2 && isWrite(curCmd);
			fallRfsh <= state == S_RFSH;
		end
	end

	// strobes: memReqN, ioReqN, rdN assert on a falling edge, release on a rising edge; wrN moves on falling edges; m1N, rfshN on rising edges
	assign cycleOn = state == S_T1 || state == S_T2 || state == S_T3 ||
		state == S_INTA;
	assign ackCycle = curCmd == CMD_INTA;
	assign curIsIo = curCmd == CMD_IO_RD || curCmd == CMD_IO_WR;
	assign curIsMem = !curIsIo && !ackCycle;
	assign memReqN = !((fallReq && cycleOn && curIsMem) ||
		(fallRfsh && state == S_RFSH));
	assign ioReqN = !(fallReq && cycleOn && (curIsIo || ackCycle));
	assign rdN = !(fallRd && cycleOn && !ackCycle);
	assign wrN = !(fallWr && (state == S_T2 || state == S_T3));
	assign m1N = !(cycleOn && (curCmd == CMD_FETCH || ackCycle));
	assign rfshN = state != S_RFSH;
	assign dataOutEn = cycleOn && isWrite(curCmd);
	assign addrOutEn = state != S_HOLD;
	assign busAckN = state != S_HOLD;

	// operand and 8-bit ALU; 16-bit steps use the shared incrementer
	always_comb
	begin
		operand = cmdReg == `SEL_ACC ? accum :
			cmdReg == `SEL_NONE ? cmdData : gp[cmdReg];
		aluSub = cmdAlu == ALU_SUB || cmdAlu == ALU_SBC || cmdAlu == ALU_CP;
		aluCarry = 1'b0;
		aluFlags = `RESET_BYTE;
		case (cmdAlu)
			ALU_ADD: {aluCarry, aluRes} = {1'b0, accum} + {1'b0, operand};
			ALU_ADC: {aluCarry, aluRes} = {1'b0, accum} + {1'b0, operand} +
				{8'h00, flags[`FLAG_C]};
			ALU_SBC: {aluCarry, aluRes} = {1'b0, accum} - {1'b0, operand} -
				{8'h00, flags[`FLAG_C]};
			ALU_AND: aluRes = accum & operand;
			ALU_XOR: aluRes = accum ^ operand;
			ALU_OR: aluRes = accum | operand;
			default: {aluCarry, aluRes} = {1'b0, accum} - {1'b0, operand};
		endcase
		aluFlags[`FLAG_S] = aluRes[7];
		aluFlags[`FLAG_Z] = aluRes == 8'h00;
		aluFlags[`FLAG_H] = accum[4] ^ operand[4] ^ aluRes[4];
		aluFlags[`FLAG_N] = aluSub;
		aluFlags[`FLAG_C] = aluCarry;
		if (cmdAlu == ALU_AND || cmdAlu == ALU_XOR || cmdAlu == ALU_OR)
			aluFlags[`FLAG_PV] = ~^aluRes;
		else
			aluFlags[`FLAG_PV] = ((accum[7] ^ operand[7]) == aluSub) &&
				(aluRes[7] != accum[7]);
	end

	// register pairs, 16-bit add, and inc/dec outside the ALU
	always_comb
	begin
		case (cmdReg[1:0])
			2'h0: pairVal = {gp[0], gp[1]};
			2'h1: pairVal = {gp[2], gp[3]};
			2'h2: pairVal = {gp[4], gp[5]};
			default: pairVal = stackPointer;
		endcase
		sum16 = {1'b0, gp[4], gp[5]} + {1'b0, pairVal};
		pairNew = step16(pairVal, cmdCode == CMD_DEC16);
	end

	// single 8-bit write port: loads, ALU result, bus read data
	always_comb
	begin
		wrEn = 1'b0;
		wrSel = `SEL_NONE;
		wrVal = cmdData;
		if (take && cmdCode == CMD_LD_REG)
		begin
			wrEn = 1'b1;
			wrSel = cmdReg;
		end
		else if (take && cmdCode == CMD_ALU8 && cmdAlu != ALU_CP)
		begin
			wrEn = 1'b1;
			wrSel = `SEL_ACC;
			wrVal = aluRes;
		end
		else if (state == S_T3 && isRead(curCmd))
		begin
			wrEn = 1'b1;
			wrSel = curReg;
			wrVal = dataIn;
		end
	end

	// register bank with alternate set; exchange swaps all of it at once
	always_ff @(posedge core_clk)
	begin
		if (sysRst)
		begin
			for (int i = 0; i < `GP_COUNT; i++)
			begin
				gp[i] <= `RESET_BYTE;
				gpAlt[i] <= `RESET_BYTE;
			end
			accum <= `RESET_BYTE;
			accAlt <= `RESET_BYTE;
			flags <= `RESET_BYTE;
			flagsAlt <= `RESET_BYTE;
			ix <= `RESET_WORD;
			iy <= `RESET_WORD;
		end
		else
		begin
			if (wrEn && wrSel == `SEL_ACC)
				accum <= wrVal;
			else if (wrEn && wrSel < `SEL_NONE)
				gp[wrSel] <= wrVal;
			if (take)
				case (cmdCode)
					CMD_ALU8: flags <= aluFlags;
					CMD_ADD16:
					begin
						{gp[4], gp[5]} <= sum16[15:0];
						flags[`FLAG_C] <= sum16[16];
						flags[`FLAG_N] <= 1'b0;
					end
					CMD_INC16, CMD_DEC16:
						case (cmdReg[1:0])
							2'h0: {gp[0], gp[1]} <= pairNew;
							2'h1: {gp[2], gp[3]} <= pairNew;
							2'h2: {gp[4], gp[5]} <= pairNew;
							default: ;
						endcase
					CMD_EXX:
					begin
						gp <= gpAlt;
						gpAlt <= gp;
						accum <= accAlt;
						accAlt <= accum;
						flags <= flagsAlt;
						flagsAlt <= flags;
					end
					CMD_LD_IDX:
						if (cmdReg[0])
							iy <= cmdAddr;
						else
							ix <= cmdAddr;
					default: ;
				endcase
		end
	end

	// response, fetched opcode and mode 0 acknowledge byte
	always_ff @(posedge core_clk)
	begin
		if (sysRst)
		begin
			respValid <= 1'b0;
			respData <= `RESET_BYTE;
			instrCode <= `RESET_BYTE;
		end
		else
		begin
			respValid <= (take && !isBus(cmdCode)) ||
				(state == S_T3 && !ackCycle);
			if (state == S_T3)
				respData <= dataIn;
			if (state == S_T3 && (curCmd == CMD_FETCH ||
				(ackCycle && intMode == IM_0)))
				instrCode <= dataIn;
		end
	end

	a_rst_filter: assert property (@(posedge core_clk) disable iff (rst)
		(!resetPinN) [*3] |=> coreRst)
		else $error("core reset missing after three low samples");
	a_rst_short: assert property (@(posedge core_clk) disable iff (rst)
		!coreRst && !resetPinN && $past(resetPinN) |=> !coreRst ##1 !coreRst
		or resetPinN)
		else $error("core reset asserted too early");
	a_rst_release: assert property (@(posedge core_clk) disable iff (rst)
		resetPinN |=> !coreRst)
		else $error("core reset held with pin high");
	a_nmi_edge: assert property (@(posedge core_clk) disable iff (sysRst)
		nmiPrev && !nmiN |=> nmiPending)
		else $error("nmi falling edge not caught");
	a_nmi_level: assert property (@(posedge core_clk) disable iff (sysRst)
		!nmiPending && !nmiPrev && !nmiN |=> !nmiPending)
		else $error("nmi taken on steady low level");
	a_nmi_serve: assert property (@(posedge core_clk) disable iff (sysRst)
		state == S_IDLE && nmiPending && busReqN |=> state == S_NMI
		##1 programCounter == NMI_VECTOR)
		else $error("pending nmi did not start service");
	a_nmi_clear: assert property (@(posedge core_clk) disable iff (sysRst)
		$rose(state == S_NMI) && !$past(nmiFall) |-> !nmiPending)
		else $error("nmi pending survived its service");
	a_wait_hold: assert property (@(posedge core_clk) disable iff (sysRst)
		state == S_T2 && !waitN |=> state == S_T2 && !rdN == $past(!rdN))
		else $error("wait state not inserted");
	a_bus_grant: assert property (@(posedge core_clk) disable iff (sysRst)
		state == S_IDLE && !busReqN |=> !busAckN && !addrOutEn && memReqN)
		else $error("bus request not granted");
	a_fetch_addr: assert property (@(posedge core_clk) disable iff (sysRst)
		take && cmdCode == CMD_FETCH |=> addrOut == $past(programCounter) &&
		programCounter == $past(programCounter) + 16'h0001)
		else $error("fetch address or pc step wrong");
	a_rfsh_step: assert property (@(posedge core_clk) disable iff (sysRst)
		state == S_RFSH |-> !rfshN && addrOut[6:0] == $past(refreshCount[6:0])
		&& refreshCount[6:0] == $past(refreshCount[6:0]) + 7'h01)
		else $error("refresh address or count wrong");
	a_wr_window: assert property (@(posedge core_clk) disable iff (sysRst)
		!wrN |-> (state == S_T2 || state == S_T3) && isWrite(curCmd))
		else $error("write strobe outside its window");
endmodule

// *** hw/cpu_front_consts.svh ***
// Summary of operation
// - Core reset asserts only after reset pin reads low three consecutive cycles.
// - Non-maskable request is taken on a falling edge of its pin only.
// - A detected edge sets a pending flag that starts a service cycle.
// - Only bus control holds falling-edge registers; all else is rising-edge.
// - Bus strobes memReqN, ioReqN, rdN combine falling-edge registers with gates, moving on both edges.
// - Fully synchronous design, no internal three-state drivers, synchronous reset.
// - A 16-bit address output reaches a 64 kilobyte space.
// - Program, data and I/O spaces are addressed separately, 64 kilobytes each.
// - Address unit forms fetch, data, jump, return addresses; steps address register.
// - Address unit holds program counter, stack pointer, vector page, refresh.
// - One non-maskable interrupt and three selectable maskable interrupt modes.
// - ALU does 8-bit ops and flags; 16-bit add and inc/dec are elsewhere.
// - Register file has main and alternate sets of general and flag registers.
// - Accumulator, six 8-bit registers as three pairs, two 16-bit index registers.
// - Cycle controller coordinates units, interrupt acceptance, bus request, waits.
// - An on-core counter generates dynamic memory refresh addresses.
`ifndef CPU_FRONT_CONSTS_SVH
`define CPU_FRONT_CONSTS_SVH
`define ADDR_W 16
`define DATA_W 8
`define GP_COUNT 6
`define RST_LOW_CYCLES 2'h3
`define RESET_WORD 16'h0000
`define RESET_SP 16'hFFFF
`define RESET_BYTE 8'h00
`define SEL_NONE 3'h6
`define SEL_ACC 3'h7
`define FLAG_S 7
`define FLAG_Z 6
`define FLAG_H 4
`define FLAG_PV 2
`define FLAG_N 1
`define FLAG_C 0
`define DEF_NMI_VECTOR 16'h0000
`define DEF_INT_VECTOR 16'h0000
`endif

// *** hw/cpu_front_pkg.sv ***
package cpu_front_pkg;
	typedef enum logic [2:0] {
		S_IDLE = 3'h0, S_T1 = 3'h1, S_T2 = 3'h3, S_T3 = 3'h2,
		S_RFSH = 3'h6, S_NMI = 3'h7, S_INTA = 3'h5, S_HOLD = 3'h4
	} state_t;
	typedef enum logic [4:0] {
		CMD_FETCH = 5'h00, CMD_MEM_RD = 5'h01, CMD_MEM_WR = 5'h02,
		CMD_IO_RD = 5'h03, CMD_IO_WR = 5'h04, CMD_PUSH = 5'h05,
		CMD_POP = 5'h06, CMD_JUMP = 5'h07, CMD_RET = 5'h08,
		CMD_LD_REG = 5'h09, CMD_ALU8 = 5'h0A, CMD_ADD16 = 5'h0B,
		CMD_INC16 = 5'h0C, CMD_DEC16 = 5'h0D, CMD_EXX = 5'h0E,
		CMD_SET_IM = 5'h0F, CMD_LD_I = 5'h10, CMD_LD_SP = 5'h11,
		CMD_LD_IDX = 5'h12, CMD_INTA = 5'h13
	} cmd_t;
	typedef enum logic [2:0] {
		ALU_ADD = 3'h0, ALU_ADC = 3'h1, ALU_SUB = 3'h2, ALU_SBC = 3'h3,
		ALU_AND = 3'h4, ALU_XOR = 3'h5, ALU_OR = 3'h6, ALU_CP = 3'h7
	} alu_op_t;
	typedef enum logic [3:0] {
		AOP_NONE = 4'h0, AOP_FETCH = 4'h1, AOP_DATA = 4'h2, AOP_PUSH = 4'h3,
		AOP_POP = 4'h4, AOP_JUMP = 4'h5, AOP_RET = 4'h6, AOP_VECTOR = 4'h7,
		AOP_RFSH = 4'h8, AOP_LDI = 4'h9, AOP_LDSP = 4'hA
	} addr_op_t;
	typedef enum logic [1:0] {
		SP_PROG = 2'h0, SP_DATA = 2'h1, SP_IO = 2'h2
	} space_t;
	typedef enum logic [1:0] {
		IM_0 = 2'h0, IM_1 = 2'h1, IM_2 = 2'h2
	} int_mode_t;

	// shared 16-bit step, kept out of the ALU
	function automatic logic [15:0] step16(input logic [15:0] v,
		input logic down);
		return down ? v - 16'h0001 : v + 16'h0001;
	endfunction
endpackage

// *** hw/addr_unit.sv ***
`timescale 1ns/100ps
`include "cpu_front_consts.svh"
module addr_unit
	import cpu_front_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic sysRst,
	// operation request
	input wire addr_op_t op,
	input wire logic [`ADDR_W-1:0] opAddr,
	// held addresses
	output logic [`ADDR_W-1:0] busAddr,
	output logic [`ADDR_W-1:0] programCounter,
	output logic [`ADDR_W-1:0] stackPointer,
	output logic [`ADDR_W-1:0] returnAddr,
	output logic [7:0] intPage,
	output logic [7:0] refreshCount
);
	// program counter and saved return address
	always_ff @(posedge core_clk)
	begin
		if (sysRst)
		begin
			programCounter <= `RESET_WORD;
			returnAddr <= `RESET_WORD;
		end
		else
			case (op)
				AOP_FETCH: programCounter <= step16(programCounter, 1'b0);
				AOP_JUMP: programCounter <= opAddr;
				AOP_RET: programCounter <= returnAddr;
				AOP_VECTOR:
				begin
					returnAddr <= programCounter;
					programCounter <= opAddr;
				end
				default: ;
			endcase
	end

	// stack pointer: pre-decrement on push, post-increment on pop
	always_ff @(posedge core_clk)
	begin
		if (sysRst)
			stackPointer <= `RESET_SP;
		else
			case (op)
				AOP_PUSH: stackPointer <= step16(stackPointer, 1'b1);
				AOP_POP: stackPointer <= step16(stackPointer, 1'b0);
				AOP_LDSP: stackPointer <= opAddr;
				default: ;
			endcase
	end

	// address register driven onto the pins
	always_ff @(posedge core_clk)
	begin
		if (sysRst)
			busAddr <= `RESET_WORD;
		else
			case (op)
				AOP_FETCH: busAddr <= programCounter;
				AOP_DATA: busAddr <= opAddr;
				AOP_PUSH: busAddr <= step16(stackPointer, 1'b1);
				AOP_POP: busAddr <= stackPointer;
				AOP_RFSH: busAddr <= {intPage, refreshCount};
				default: ;
			endcase
	end

	// vector page and refresh counter; bit 7 of refresh is left alone
	always_ff @(posedge core_clk)
	begin
		if (sysRst)
		begin
			intPage <= `RESET_BYTE;
			refreshCount <= `RESET_BYTE;
		end
		else
		begin
			if (op == AOP_LDI)
				intPage <= opAddr[7:0];
			if (op == AOP_RFSH)
				refreshCount <= {refreshCount[7],
					refreshCount[6:0] + 7'h01};
		end
	end
endmodule

// *** dv/ext_bus_model.sv ***
`timescale 1ns/100ps
module ext_bus_model
	import cpu_front_pkg::*;
(
	// clock
	input wire logic core_clk,
	// core bus
	input wire logic [15:0] addrOut,
	input wire logic [7:0] dataOut,
	input wire logic memReqN,
	input wire logic ioReqN,
	input wire logic rdN,
	input wire logic wrN,
	input wire space_t space,
	output logic [7:0] dataIn,
	output logic waitN,
	// test control
	input wire logic [1:0] waits
);
	logic [7:0] mem [logic [17:0]];
	logic [7:0] junk = 8'h5A;
	int cnt = 0;

	// unwritten places answer a value derived from space and address
	function automatic logic [7:0] peek(input logic [17:0] k);
		return mem.exists(k) ? mem[k] : k[7:0] ^ k[15:8] ^ {6'h00, k[17:16]};
	endfunction

	// each space keeps its own contents
	always @(negedge wrN)
		if (!memReqN || !ioReqN)
			mem[{space, addrOut}] = dataOut;

	// released data lines toggle so a stale byte cannot pass as a read
	always @(posedge core_clk)
		junk <= ~junk;
	always @*
		dataIn = (!rdN && (!memReqN || !ioReqN)) ?
			peek({space, addrOut}) : junk;

	// wait states: hold waitN low for the requested count per access
	initial waitN = 1'b1;
	always @(posedge core_clk)
		if (memReqN && ioReqN)
		begin
			cnt <= 0;
			waitN <= 1'b1;
		end
		else if (cnt < waits)
		begin
			cnt <= cnt + 1;
			waitN <= 1'b0;
		end
		else
			waitN <= 1'b1;
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/100ps
`include "cpu_front_consts.svh"
module testbench
	import cpu_front_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic resetPinN = 1'b1;
	logic nmiN = 1'b1;
	logic intN = 1'b1;
	logic busReqN = 1'b1;
	logic cmdValid = 1'b0;
	cmd_t cmdCode = CMD_FETCH;
	logic [2:0] cmdReg = 3'h0;
	alu_op_t cmdAlu = ALU_ADD;
	logic [15:0] cmdAddr = 16'h0000;
	logic [7:0] cmdData = 8'h00;
	logic [1:0] waits = 2'h0;
	logic waitN, coreRst, nmiPending, addrOutEn, dataOutEn, memReqN, ioReqN;
	logic rdN, wrN, m1N, rfshN, busAckN, cmdReady, respValid;
	logic [15:0] addrOut, programCounter, stackPointer, lastAddr, rfshAddr, r0;
	logic [7:0] dataIn, dataOut, respData, accum, flags, instrCode;
	space_t space;
	int_mode_t intMode;
	int mismatches = 0;
	int checked = 0;
	int lat;
	int nmiCount = 0;
	logic sawM1, sawWr, sawRfsh;

	cpu_core_control_front_end #(
		.NMI_VECTOR(16'h0100),
		.INT_VECTOR(16'h0200)
	) DUT (
		.core_clk(core_clk), .rst(rst), .resetPinN(resetPinN),
		.coreRst(coreRst), .nmiN(nmiN), .intN(intN), .nmiPending(nmiPending),
		.addrOut(addrOut), .addrOutEn(addrOutEn), .dataIn(dataIn),
		.dataOut(dataOut), .dataOutEn(dataOutEn), .memReqN(memReqN),
		.ioReqN(ioReqN), .rdN(rdN), .wrN(wrN), .m1N(m1N), .rfshN(rfshN),
		.space(space), .waitN(waitN), .busReqN(busReqN), .busAckN(busAckN),
		.cmdValid(cmdValid), .cmdCode(cmdCode), .cmdReg(cmdReg),
		.cmdAlu(cmdAlu), .cmdAddr(cmdAddr), .cmdData(cmdData),
		.cmdReady(cmdReady), .respValid(respValid), .respData(respData),
		.programCounter(programCounter), .stackPointer(stackPointer),
		.accum(accum), .flags(flags), .instrCode(instrCode),
		.intMode(intMode));

	ext_bus_model mem (
		.core_clk(core_clk), .addrOut(addrOut), .dataOut(dataOut),
		.memReqN(memReqN), .ioReqN(ioReqN), .rdN(rdN), .wrN(wrN),
		.space(space), .dataIn(dataIn), .waitN(waitN), .waits(waits));

	always #12.5 core_clk = ~core_clk;

	// strobe watchers catch pulses too short to poll
	always @(negedge m1N) sawM1 = 1'b1;
	always @(negedge wrN) sawWr = dataOutEn; // data must drive as wrN falls
	always @(negedge rfshN) sawRfsh = 1'b1;
	always @(posedge nmiPending) nmiCount++;
	always @(negedge memReqN)
		if (rfshN === 1'b0)
			rfshAddr = addrOut;
		else
			lastAddr = addrOut;

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask

	// one command; lat counts cycles from take to the response pulse
	task automatic cmd(input cmd_t c, input logic [2:0] r, input alu_op_t a,
		input logic [15:0] ad, input logic [7:0] d);
		int n;
		cyc(1);
		{sawM1, sawWr, sawRfsh} = 3'h0;
		cmdCode = c;
		cmdReg = r;
		cmdAlu = a;
		cmdAddr = ad;
		cmdData = d;
		cmdValid = 1'b1;
		n = 0;
		@(negedge core_clk);
		while (cmdReady !== 1'b1 && n < 50)
		begin
			@(negedge core_clk);
			n++;
		end
		cyc(1);
		cmdValid = 1'b0;
		lat = 0;
		do
		begin
			@(negedge core_clk);
			lat++;
		end
		while (respValid !== 1'b1 && lat < 50);
		chk({n < 50, lat < 50}, 2'h3);
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// watchdog: far beyond the roughly 125 cycles the tests need
	initial
	begin
		#400000;
		mismatches++;
		conclude;
	end

	initial
	begin
		repeat (12) @(posedge core_clk);
		#2 rst = 1'b0;
		cyc(2);
		chk(programCounter, 16'h0000);
		chk(stackPointer, 16'hFFFF);
		chk({accum, flags}, 16'h0000);
		chk({memReqN, ioReqN, rdN, wrN, m1N, rfshN, busAckN, coreRst}, 8'hFE);
		$display("reset test done");

		cmd(CMD_MEM_WR, 3'h0, ALU_ADD, 16'hFFFF, 8'hA5);
		chk(lastAddr, 16'hFFFF);
		chk(sawWr, 1'h1);
		cmd(CMD_MEM_RD, 3'h7, ALU_ADD, 16'hFFFF, 8'h00);
		chk(lat, 4);
		chk({respData, accum}, 16'hA5A5);
		chk(space, SP_DATA);
		cmd(CMD_IO_RD, 3'h7, ALU_ADD, 16'hFFFF, 8'h00);
		chk(respData, 8'h02);
		chk(space, SP_IO);
		waits = 2'h1;
		cmd(CMD_MEM_RD, 3'h7, ALU_ADD, 16'hFFFF, 8'h00);
		chk(lat, 5);
		waits = 2'h0;
		cmd(CMD_PUSH, 3'h0, ALU_ADD, 16'h0000, 8'h6B);
		chk(stackPointer, 16'hFFFE);
		cmd(CMD_POP, 3'h7, ALU_ADD, 16'h0000, 8'h00);
		chk(stackPointer, 16'hFFFF);
		chk({lastAddr[7:0], accum}, 16'hFE6B);
		$display("bus test done");

		cmd(CMD_JUMP, 3'h0, ALU_ADD, 16'hFFFE, 8'h00);
		cmd(CMD_FETCH, 3'h0, ALU_ADD, 16'h0000, 8'h00);
		cyc(3);
		chk(instrCode, 8'h01);
		chk(programCounter, 16'hFFFF);
		chk({sawM1, sawRfsh}, 2'h3);
		chk(space, SP_PROG);
		r0 = rfshAddr;
		cmd(CMD_FETCH, 3'h0, ALU_ADD, 16'h0000, 8'h00);
		cyc(3);
		chk(programCounter, 16'h0000);
		chk(rfshAddr, {8'h00, r0[7], r0[6:0] + 7'h01});
		$display("fetch test done");

		cmd(CMD_LD_REG, 3'h7, ALU_ADD, 16'h0000, 8'h3C);
		chk(lat, 1);
		cmd(CMD_ALU8, 3'h6, ALU_ADD, 16'h0000, 8'h05);
		chk(accum, 8'h41);
		cmd(CMD_EXX, 3'h0, ALU_ADD, 16'h0000, 8'h00);
		chk(accum, 8'h00);
		cmd(CMD_EXX, 3'h0, ALU_ADD, 16'h0000, 8'h00);
		chk(accum, 8'h41);
		cmd(CMD_ALU8, 3'h6, ALU_SUB, 16'h0000, 8'h41);
		chk(accum, 8'h00);
		chk(flags[`FLAG_Z], 1'h1);
		$display("alu test done");

		cmd(CMD_JUMP, 3'h0, ALU_ADD, 16'h1234, 8'h00);
		cyc(1);
		nmiCount = 0;
		nmiN = 1'b0;
		cyc(10);
		chk(nmiCount, 1);
		chk(programCounter, 16'h0100);
		chk(nmiPending, 1'h0);
		cmd(CMD_RET, 3'h0, ALU_ADD, 16'h0000, 8'h00);
		chk(programCounter, 16'h1234);
		cyc(1);
		nmiN = 1'b1;
		cyc(2);
		nmiN = 1'b0;
		cyc(10);
		chk(nmiCount, 2);
		nmiN = 1'b1;
		$display("nmi test done");

		busReqN = 1'b0;
		cyc(3);
		chk({busAckN, addrOutEn, cmdReady}, 3'h0);
		busReqN = 1'b1;
		cyc(3);
		chk({busAckN, addrOutEn}, 2'h3);
		$display("hold test done");

		cmd(CMD_SET_IM, 3'h0, ALU_ADD, 16'h0000, 8'h05);
		cyc(1);
		sawM1 = 1'b0;
		intN = 1'b0;
		cyc(6);
		chk(programCounter, 16'h0200);
		chk({intMode, sawM1}, 3'h3);
		intN = 1'b1;
		$display("interrupt test done");

		resetPinN = 1'b0;
		cyc(2);
		chk(coreRst, 1'h0);
		resetPinN = 1'b1;
		cyc(1);
		resetPinN = 1'b0;
		cyc(2);
		chk(coreRst, 1'h0);
		cyc(1);
		chk(coreRst, 1'h1);
		resetPinN = 1'b1;
		cyc(1);
		chk(coreRst, 1'h0);
		chk(programCounter, 16'h0000);
		$display("reset pin test done");
		conclude;
	end
endmodule
